// *** verilog/sfe_core.sv ***
// Serial flash instruction handler: full erase, sleep, wake and identity reads
`timescale 1ns/1ps
module sfe_core #(
  parameter logic [7:0] MFR_ID      = 8'hA5,  // Arbitrary value
  parameter logic [7:0] DEV_ID      = 8'h3C,  // Arbitrary value
  parameter logic [7:0] MEM_TYPE_ID = 8'h40,  // Arbitrary value
  parameter logic [7:0] CAP_ID      = 8'h13,  // Arbitrary value
  parameter int         ERASE_CYC   = sfe_pkg::FULL_ERASE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       serial_in,
  input  wire logic [3:0] protect_level_bits,
  input  wire logic       quad_mode,
  input  wire logic       ext_write_busy,
  output logic            serial_out,
  output logic            serial_out_oe_n,
  output logic            write_latch_flag,
  output logic            write_in_progress,
  output logic            deep_sleep,
  output logic            array_erase_strobe
);

  // ****************************************************
  // Pin synchronisation and edges
  // ****************************************************
  logic [2:0]         pins_s;
  logic               cs_s, sck_s, din_s, cs_d_r, sck_d_r;
  logic               sck_rise, sck_fall, cs_rise, cs_fall;

  sfe_sync2 #(.W(3)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .d       ({cs_n, sclk, serial_in}),
    .rst_val ({sfe_pkg::RST_PIN, 2'h0}),
    .q       (pins_s)
  );
  assign cs_s  = pins_s[2];
  assign sck_s = pins_s[1];
  assign din_s = pins_s[0];

  // Edge history taken from the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_d_r  <= sfe_pkg::RST_PIN;
      sck_d_r <= 1'b0;
    end else if (ce) begin
      cs_d_r  <= cs_s;
      sck_d_r <= sck_s;
    end
  end
  assign sck_rise = ce & ~cs_s & sck_s & ~sck_d_r;
  assign sck_fall = ce & ~cs_s & ~sck_s & sck_d_r;
  assign cs_rise  = ce & cs_s & ~cs_d_r;
  assign cs_fall  = ce & ~cs_s & cs_d_r;

  // ****************************************************
  // Shift-in and framing
  // ****************************************************
  sfe_pkg::sfe_state_e state_r;
  logic [7:0]  sh_r, op_r;
  logic [7:0]  byte_nxt;
  logic [5:0]  bit_cnt_r;
  logic [23:0] out_word_r;
  logic [4:0]  out_len_r, out_idx_r;
  logic        busy_any, pwr_busy, erase_busy, pwr_done, pwr_waking_r;
  logic        erase_go, sleep_go, wake_go;
  logic [sfe_pkg::TIMER_W-1:0] pwr_load;

  assign byte_nxt = {sh_r[6:0], din_s};
  assign busy_any = erase_busy | ext_write_busy | pwr_busy;

  // Bits are shifted in on serial clock rising edges
  always_ff @(posedge clk) begin
    if (rst) begin
      sh_r      <= 8'h00;
      bit_cnt_r <= 6'h00;
    end else if (cs_fall) begin
      bit_cnt_r <= 6'h00;
    end else if (sck_rise) begin
      sh_r <= byte_nxt;
      if (bit_cnt_r != 6'h3F) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  // Instruction sequencer; a deselect always returns to idle
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= sfe_pkg::ST_IDLE;
      op_r       <= 8'h00;
      out_word_r <= 24'h000000;
      out_len_r  <= sfe_pkg::LEN_ID1;
    end else if (cs_rise) begin
      state_r <= sfe_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_r <= sfe_pkg::ST_OPCODE;
    end else if (sck_rise) begin
      case (state_r)
        sfe_pkg::ST_OPCODE: begin
          if (bit_cnt_r == sfe_pkg::OPCODE_BITS - 6'h01) begin
            op_r <= byte_nxt;
            if (busy_any) begin
              state_r <= sfe_pkg::ST_SKIP;
            end else if (deep_sleep) begin
              // Asleep only the wake opcode gets through; reset opcodes land here too
              state_r <= (byte_nxt == sfe_pkg::OP_WAKE) ? sfe_pkg::ST_DUMMY : sfe_pkg::ST_SKIP;
            end else begin
              case (byte_nxt)
                sfe_pkg::OP_WAKE:   state_r <= sfe_pkg::ST_DUMMY;
                sfe_pkg::OP_MFR_DEV: state_r <= quad_mode ? sfe_pkg::ST_SKIP : sfe_pkg::ST_ADDR;
                sfe_pkg::OP_IDENT3: begin
                  state_r    <= quad_mode ? sfe_pkg::ST_SKIP : sfe_pkg::ST_OUT;
                  out_word_r <= {MFR_ID, MEM_TYPE_ID, CAP_ID};
                  out_len_r  <= sfe_pkg::LEN_ID3;
                end
                sfe_pkg::OP_UNLOCK, sfe_pkg::OP_ERASE_A, sfe_pkg::OP_ERASE_B, sfe_pkg::OP_SLEEP:
                  state_r <= sfe_pkg::ST_OPDONE;
                default: state_r <= sfe_pkg::ST_SKIP;
              endcase
            end
          end
        end
        // A ninth bit voids an opcode-only instruction
        sfe_pkg::ST_OPDONE: state_r <= sfe_pkg::ST_SKIP;
        sfe_pkg::ST_ADDR: begin
          if (bit_cnt_r == sfe_pkg::FRAME_BITS - 6'h01) begin
            state_r    <= sfe_pkg::ST_OUT;
            out_len_r  <= sfe_pkg::LEN_ID2;
            // Only the lowest address bit picks the order
            out_word_r <= din_s ? {DEV_ID, MFR_ID, 8'h00} : {MFR_ID, DEV_ID, 8'h00};
          end
        end
        sfe_pkg::ST_DUMMY: begin
          if (bit_cnt_r == sfe_pkg::FRAME_BITS - 6'h01) begin
            state_r    <= sfe_pkg::ST_OUT;
            out_len_r  <= sfe_pkg::LEN_ID1;
            out_word_r <= {DEV_ID, 16'h0000};
          end
        end
        sfe_pkg::ST_IDLE, sfe_pkg::ST_OUT, sfe_pkg::ST_SKIP: state_r <= state_r;
        default: state_r <= sfe_pkg::ST_SKIP;
      endcase
    end
  end

  // ****************************************************
  // Serial output
  // ****************************************************
  // Bits change on falling edges and wrap at the word length
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_out      <= 1'b0;
      serial_out_oe_n <= sfe_pkg::RST_PIN;
      out_idx_r       <= 5'h00;
    end else if (cs_rise || cs_fall) begin
      serial_out_oe_n <= 1'b1;
      out_idx_r       <= 5'h00;
    end else if (sck_fall && state_r == sfe_pkg::ST_OUT) begin
      serial_out      <= out_word_r[5'h17 - out_idx_r];
      serial_out_oe_n <= 1'b0;
      out_idx_r       <= (out_idx_r == out_len_r - 5'h01) ? 5'h00 : out_idx_r + 5'h01;
    end
  end

  // ****************************************************
  // Actions on deselect
  // ****************************************************
  assign erase_go = cs_rise && state_r == sfe_pkg::ST_OPDONE && write_latch_flag
                    && (op_r == sfe_pkg::OP_ERASE_A || op_r == sfe_pkg::OP_ERASE_B)
                    && protect_level_bits == 4'h0;
  assign sleep_go = cs_rise && state_r == sfe_pkg::ST_OPDONE && op_r == sfe_pkg::OP_SLEEP;
  assign wake_go  = cs_rise && deep_sleep && op_r == sfe_pkg::OP_WAKE
                    && (state_r == sfe_pkg::ST_DUMMY || state_r == sfe_pkg::ST_OUT);
  // Bare opcode gets the wake delay, a longer frame the wake-to-standby delay
  assign pwr_load = sleep_go ? sfe_pkg::TIMER_W'(sfe_pkg::SLEEP_ENTRY_CYC) :
                    (bit_cnt_r == sfe_pkg::OPCODE_BITS) ? sfe_pkg::TIMER_W'(sfe_pkg::WAKE_DELAY_CYC) :
                    sfe_pkg::TIMER_W'(sfe_pkg::WAKE_STANDBY_CYC);

  sfe_timer u_erase_tmr (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .start (erase_go),
    .load  (sfe_pkg::TIMER_W'(ERASE_CYC)),
    .busy  (erase_busy),
    .done  ()
  );

  sfe_timer u_pwr_tmr (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .start (sleep_go | wake_go),
    .load  (pwr_load),
    .busy  (pwr_busy),
    .done  (pwr_done)
  );
  assign write_in_progress = erase_busy;

  // Write latch: set by decoded unlock, cleared as erase starts
  always_ff @(posedge clk) begin
    if (rst) begin
      write_latch_flag <= sfe_pkg::RST_LATCH;
    end else if (ce) begin
      if (cs_rise && state_r == sfe_pkg::ST_OPDONE && op_r == sfe_pkg::OP_UNLOCK) begin
        write_latch_flag <= 1'b1;
      end else if (erase_go) begin
        write_latch_flag <= 1'b0;
      end
    end
  end

  // Erase strobe tells the array to fill with FFh
  always_ff @(posedge clk) begin
    if (rst) begin
      array_erase_strobe <= 1'b0;
    end else if (ce) begin
      array_erase_strobe <= erase_go;
    end
  end

  // Sleep flag changes only when the power timer finishes
  always_ff @(posedge clk) begin
    if (rst) begin
      deep_sleep   <= sfe_pkg::RST_SLEEP;
      pwr_waking_r <= 1'b0;
    end else if (ce) begin
      if (sleep_go || wake_go) begin
        pwr_waking_r <= wake_go;
      end
      if (pwr_done) begin
        deep_sleep <= ~pwr_waking_r;
      end
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  AST_ERASE_WIP: assert property (@(posedge clk) disable iff (rst)
    erase_go |=> write_in_progress [*2]) else $error("erase did not raise write_in_progress");

  AST_ERASE_LATCH: assert property (@(posedge clk) disable iff (rst)
    erase_go |=> !write_latch_flag) else $error("write latch still set during erase");

  AST_ERASE_GUARD: assert property (@(posedge clk) disable iff (rst)
    $rose(array_erase_strobe) |-> $past(protect_level_bits) == 4'h0 && $past(write_latch_flag))
    else $error("erase started without unlock or with protection");

  AST_ERASE_LENGTH: assert property (@(posedge clk) disable iff (rst)
    erase_go |-> bit_cnt_r == sfe_pkg::OPCODE_BITS) else $error("erase from wrong frame point");

  AST_SLEEP_SOURCE: assert property (@(posedge clk) disable iff (rst)
    $rose(deep_sleep) |-> $past(pwr_done) && !pwr_waking_r) else $error("sleep entered without sleep opcode");

  AST_SLEEP_BUSY: assert property (@(posedge clk) disable iff (rst)
    (sck_rise && state_r == sfe_pkg::ST_OPCODE && bit_cnt_r == 6'h07 && erase_busy)
    |=> state_r == sfe_pkg::ST_SKIP) else $error("opcode decoded during write cycle");

  AST_SLEEP_IGNORE: assert property (@(posedge clk) disable iff (rst)
    (sck_rise && deep_sleep && !busy_any && state_r == sfe_pkg::ST_OPCODE && bit_cnt_r == 6'h07
     && byte_nxt != sfe_pkg::OP_WAKE) |=> state_r == sfe_pkg::ST_SKIP) else $error("opcode taken while asleep");

  AST_QUAD_BLOCK: assert property (@(posedge clk) disable iff (rst)
    (sck_rise && quad_mode && state_r == sfe_pkg::ST_OPCODE && bit_cnt_r == 6'h07)
    |=> state_r != sfe_pkg::ST_ADDR && state_r != sfe_pkg::ST_OUT) else $error("identity read in quad mode");

  AST_OE_OUT: assert property (@(posedge clk) disable iff (rst)
    !serial_out_oe_n |-> state_r == sfe_pkg::ST_OUT && !cs_d_r) else $error("output driven outside data phase");

endmodule

// *** verilog/sfe_pkg.sv ***
// Shared constants, opcodes and states for the serial flash erase/sleep/identify block
package sfe_pkg;

  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int CLK_PERIOD_NS      = 5;
  localparam int SLEEP_ENTRY_NS     = 3000;          // sleep_entry_delay
  localparam int WAKE_DELAY_NS      = 3000;          // wake_delay
  localparam int WAKE_STANDBY_NS    = 1800;          // wake_standby_delay
  localparam int FULL_ERASE_NS      = 1000000000;    // full_erase_time

  // Longest times round down, never below one cycle
  function automatic int cyc_floor(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SLEEP_ENTRY_CYC    = cyc_floor(SLEEP_ENTRY_NS);
  localparam int WAKE_DELAY_CYC     = cyc_floor(WAKE_DELAY_NS);
  localparam int WAKE_STANDBY_CYC   = cyc_floor(WAKE_STANDBY_NS);
  localparam int FULL_ERASE_CYC     = cyc_floor(FULL_ERASE_NS);
  localparam int TIMER_W            = 32;

  // ****************************************************
  // Opcodes and frame lengths
  // ****************************************************
  localparam logic [7:0] OP_UNLOCK   = 8'h06;        // write_unlock_cmd
  localparam logic [7:0] OP_ERASE_A  = 8'hC7;
  localparam logic [7:0] OP_ERASE_B  = 8'h60;
  localparam logic [7:0] OP_SLEEP    = 8'hB9;
  localparam logic [7:0] OP_WAKE     = 8'hAB;        // wake_and_identify
  localparam logic [7:0] OP_MFR_DEV  = 8'h90;
  localparam logic [7:0] OP_IDENT3   = 8'h9F;        // three_byte_identify
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] FRAME_BITS  = 6'h20;        // opcode plus three bytes
  localparam logic [4:0] LEN_ID1     = 5'h08;
  localparam logic [4:0] LEN_ID2     = 5'h10;
  localparam logic [4:0] LEN_ID3     = 5'h18;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic RST_LATCH = 1'b0;
  localparam logic RST_SLEEP = 1'b0;
  localparam logic RST_PIN   = 1'b1;

  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_OPDONE, ST_ADDR, ST_DUMMY, ST_OUT, ST_SKIP} sfe_state_e;

endpackage

// *** verilog/sfe_sync2.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfe_sync2 #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage; reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= rst_val;
      q      <= rst_val;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** verilog/sfe_timer.sv ***
// Loadable down-counter for self-timed cycles
`timescale 1ns/1ps
module sfe_timer (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire logic                         start,
  input  wire logic [sfe_pkg::TIMER_W-1:0]  load,
  output logic                              busy,
  output logic                              done
);
  logic [sfe_pkg::TIMER_W-1:0] cnt_r;

  // Counts load cycles after start, then pulses done once
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= load;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_r <= 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end
endmodule

// *** test/sfe_host_model.sv ***
// Host SPI master model that shifts frames into the flash instruction handler
`timescale 1ns/1ps
module sfe_host_model #(
  parameter int HALF = 6  // Clocks per serial clock level; the device needs at least three
) (
  input  wire logic clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n,
  output logic      cs_n,
  output logic      sclk,
  output logic      serial_in
);
  logic oe_seen;
  logic cs_n_d;

  // ****************************************************
  // Idle state and output watch
  // ****************************************************
  initial begin
    cs_n      = 1'b1;
    sclk      = 1'b0;
    serial_in = 1'b0;
  end

  // Remembers whether the device drove its data pin during the current frame; cleared as select falls
  always @(posedge clk) begin
    cs_n_d <= cs_n;
    if (cs_n === 1'b0 && cs_n_d === 1'b1) begin
      oe_seen <= 1'b0;
    end else if (cs_n === 1'b0 && serial_out_oe_n === 1'b0) begin
      oe_seen <= 1'b1;
    end
  end

  // ****************************************************
  // Frame task
  // ****************************************************
  // Serial clock stands low outside frames; gap holds select high afterwards
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx, input int gap,
                       output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(negedge clk);
    cs_n    = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      serial_in = (i < ntx) ? tx[31 - i] : ~serial_in;
      repeat (HALF) @(negedge clk);
      if (i >= ntx) begin
        rx = {rx[30:0], serial_out ^ serial_out_oe_n};             // Undriven line reads inverted
      end
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    cs_n      = 1'b1;
    serial_in = ~serial_in;                                        // Released line keeps moving
    repeat (gap) @(negedge clk);
  endtask
endmodule

// *** test/sfe_core_tb.sv ***
// Self-checking testbench for the flash erase, sleep, wake and identity handler
`timescale 1ns/1ps
module sfe_core_tb;
  localparam int         ERASE_N  = 1500;
  localparam logic [7:0] ID_MFR   = 8'h5A;  // Arbitrary value
  localparam logic [7:0] ID_DEV   = 8'hC3;  // Arbitrary value
  localparam logic [7:0] ID_MEM   = 8'h21;  // Arbitrary value
  localparam logic [7:0] ID_CAP   = 8'h12;  // Arbitrary value
  localparam logic [7:0] OP_ARM   = 8'h66;  // Software reset-arm opcode
  localparam logic [7:0] OP_RSTGO = 8'h99;  // Software reset opcode

  logic        clk;
  logic        rst;
  logic        ce;
  logic        quad_mode;
  logic        ext_write_busy;
  logic [3:0]  protect_level_bits;
  logic        cs_n;
  logic        sclk;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe_n;
  logic        write_latch_flag;
  logic        write_in_progress;
  logic        deep_sleep;
  logic        array_erase_strobe;
  logic [31:0] rx;
  logic [7:0]  erase_ops [2];
  int          miscompares;
  int          checked;
  int          strobes;

  // ****************************************************
  // Clock, design and host
  // ****************************************************
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  sfe_core #(.MFR_ID(ID_MFR), .DEV_ID(ID_DEV), .MEM_TYPE_ID(ID_MEM), .CAP_ID(ID_CAP), .ERASE_CYC(ERASE_N)) DUT (
    .clk                (clk),
    .rst                (rst),
    .ce                 (ce),
    .cs_n               (cs_n),
    .sclk               (sclk),
    .serial_in          (serial_in),
    .protect_level_bits (protect_level_bits),
    .quad_mode          (quad_mode),
    .ext_write_busy     (ext_write_busy),
    .serial_out         (serial_out),
    .serial_out_oe_n    (serial_out_oe_n),
    .write_latch_flag   (write_latch_flag),
    .write_in_progress  (write_in_progress),
    .deep_sleep         (deep_sleep),
    .array_erase_strobe (array_erase_strobe)
  );

  sfe_host_model host (
    .clk             (clk),
    .serial_out      (serial_out),
    .serial_out_oe_n (serial_out_oe_n),
    .cs_n            (cs_n),
    .sclk            (sclk),
    .serial_in       (serial_in)
  );

  // Counts fill pulses; a one-cycle strobe is easy to miss by polling
  always @(posedge clk) begin
    if (array_erase_strobe === 1'b1) begin
      strobes++;
    end
  end

  // ****************************************************
  // Checking and control tasks
  // ****************************************************
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bounded wait on write_in_progress (sel 0) or deep_sleep (sel 1)
  task automatic wait_for(input int sel, input logic val, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? write_in_progress : deep_sleep) !== val) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("MISMATCH at %0t ns: wait ran out, got %h expected %h", $time, ~val, val);
        finish_test();
      end
    end
  endtask

  task automatic cmd(input logic [7:0] op, input int nbits, input int gap);
    host.frame({op, 24'h00_0000}, nbits, 0, gap, rx);
  endtask

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    quad_mode = 1'b0;
    ext_write_busy = 1'b0;
    protect_level_bits = 4'h0;
    miscompares = 0;
    checked = 0;
    strobes = 0;
    erase_ops[0] = 8'hC7;
    erase_ops[1] = 8'h60;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    check_bit(deep_sleep, 1'b0);
    check_bit(write_in_progress, 1'b0);
    check_bit(serial_out_oe_n, 1'b1);
    // Identity reads, awake and in quad mode
    host.frame({8'h9F, 24'h0}, 8, 32, 8, rx);
    check_word(rx, {ID_MFR, ID_MEM, ID_CAP, ID_MFR});
    host.frame({8'h90, 24'h00_0000}, 32, 16, 8, rx);
    check_word(rx, {16'h0, ID_MFR, ID_DEV});
    host.frame({8'h90, 24'h00_0001}, 32, 16, 8, rx);
    check_word(rx, {16'h0, ID_DEV, ID_MFR});
    host.frame({8'hAB, 24'h0}, 32, 16, 8, rx);
    check_word(rx, {16'h0, ID_DEV, ID_DEV});
    quad_mode = 1'b1;
    host.frame({8'h9F, 24'h0}, 8, 8, 8, rx);
    check_bit(host.oe_seen, 1'b0);
    host.frame({8'h90, 24'h0}, 32, 8, 8, rx);
    check_bit(host.oe_seen, 1'b0);
    quad_mode = 1'b0;
    $display("Test identity reads done");
    // Refused erase and sleep requests leave flags alone
    cmd(8'hC7, 8, 20);
    check_bit(write_in_progress, 1'b0);
    cmd(8'h06, 8, 8);
    check_bit(write_latch_flag, 1'b1);
    protect_level_bits = 4'h8;
    cmd(8'hC7, 8, 20);
    check_bit(write_in_progress, 1'b0);
    check_bit(write_latch_flag, 1'b1);
    protect_level_bits = 4'h0;
    cmd(8'hC7, 9, 20);
    check_bit(write_in_progress, 1'b0);
    ext_write_busy = 1'b1;
    cmd(8'hB9, 8, 700);
    check_bit(deep_sleep, 1'b0);
    ext_write_busy = 1'b0;
    check_word(32'(strobes), 32'h0);
    $display("Test refused requests done");
    // Both erase opcodes, with traffic while the cycle runs
    for (int k = 0; k < 2; k++) begin
      cmd(8'h06, 8, 8);
      cmd(erase_ops[k], 8, 8);
      check_bit(write_in_progress, 1'b1);
      check_bit(write_latch_flag, 1'b0);
      check_word(32'(strobes), 32'(k + 1));
      cmd(8'hB9, 8, 8);
      host.frame({8'h9F, 24'h0}, 8, 8, 8, rx);
      check_bit(host.oe_seen, 1'b0);
      host.frame({8'hAB, 24'h0}, 32, 8, 8, rx);
      check_bit(host.oe_seen, 1'b0);
      check_bit(write_in_progress, 1'b1);
      wait_for(0, 1'b0, ERASE_N);
      repeat (700) @(negedge clk);
      check_bit(deep_sleep, 1'b0);
    end
    $display("Test full erase done");
    // Sleep entry, ignored opcodes, both wake forms, reset
    cmd(8'hB9, 8, 500);
    check_bit(deep_sleep, 1'b0);
    wait_for(1, 1'b1, 200);
    host.frame({8'h90, 24'h0}, 32, 8, 8, rx);
    check_bit(host.oe_seen, 1'b0);
    cmd(8'h06, 8, 8);
    check_bit(write_latch_flag, 1'b0);
    cmd(OP_ARM, 8, 8);
    cmd(OP_RSTGO, 8, 8);
    check_bit(deep_sleep, 1'b1);
    cmd(8'hAB, 8, 500);
    check_bit(deep_sleep, 1'b1);
    wait_for(1, 1'b0, 200);
    host.frame({8'h9F, 24'h0}, 8, 8, 8, rx);
    check_word(rx, {24'h0, ID_MFR});
    cmd(8'hB9, 8, 8);
    wait_for(1, 1'b1, 700);
    host.frame({8'hAB, 24'h0}, 32, 8, 300, rx);
    check_word(rx, {24'h0, ID_DEV});
    check_bit(deep_sleep, 1'b1);
    // Clock enable low must freeze the wake timer
    ce = 1'b0;
    repeat (200) @(negedge clk);
    check_bit(deep_sleep, 1'b1);
    ce = 1'b1;
    wait_for(1, 1'b0, 120);
    cmd(8'hB9, 8, 8);
    wait_for(1, 1'b1, 700);
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check_bit(deep_sleep, 1'b0);
    $display("Test sleep and wake done");
    finish_test();
  end
endmodule
